// ---- design/front_panel_key_matrix_scanner.sv ----
// front panel key matrix scanner over six shared open-drain key lines
`default_nettype none
module front_panel_key_matrix_scanner #(
	parameter int STEP_CYCLES = key_scan_pkg::STEP_CYCLES
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// key lines 1..6 on bits 0..5, as open-drain pins
	input wire logic [5:0] key_line_in,
	output logic [5:0] key_line_out,
	output logic [5:0] key_line_oe_out,
	// key report
	output logic [key_scan_pkg::KEY_COUNT-1:0] key_closed_out,
	output logic scan_done_out,
	output logic [2:0] scan_step_out
);
	typedef enum logic [1:0] {ST_SETTLE, ST_SAMPLE, ST_NEXT} phase_type;

	localparam int CW = $clog2(STEP_CYCLES + 1);
	localparam logic [CW-1:0] SETTLE_LAST = CW'(STEP_CYCLES - 1);

	phase_type phase_reg;
	logic [2:0] step_reg;
	logic [CW-1:0] count_reg;
	logic [5:0] line_level;
	key_scan_pkg::key_report_type report_reg;
	logic [key_scan_pkg::KEY_COUNT-1:0] frame_reg;
	logic [key_scan_pkg::KEY_COUNT-1:0] frame_next;
	key_scan_pkg::key_line_drive_type drive_reg;

	// pins pass two flops before any logic reads them
	key_line_sync #(
		.WIDTH(key_scan_pkg::LINE_COUNT)
	) u_sync (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.pin_in(key_line_in),
		.level_out(line_level)
	);

	// step sequencer: settle, sample, advance
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			phase_reg <= ST_SETTLE;
			step_reg <= key_scan_pkg::STEP_FIRST;
			count_reg <= '0;
		end
		else
		begin
			unique case (phase_reg)
				ST_SETTLE:
				begin
					if (count_reg == SETTLE_LAST)
					begin
						phase_reg <= ST_SAMPLE;
						count_reg <= '0;
					end
					else
						count_reg <= count_reg + 1'b1;
				end
				ST_SAMPLE:
					phase_reg <= ST_NEXT;
				ST_NEXT:
				begin
					phase_reg <= ST_SETTLE;
					if (step_reg == key_scan_pkg::STEP_LAST)
						step_reg <= key_scan_pkg::STEP_FIRST;
					else
						step_reg <= step_reg + 3'h1;
				end
			endcase
		end
	end

	// line drive: value fixed at zero, enable picks the strobe of the step
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			drive_reg <= '{out_val: 6'h00, out_en: 6'h00};
		else
		begin
			drive_reg.out_val <= 6'h00;
			drive_reg.out_en <= key_scan_pkg::DRIVE_MASK[step_reg];
		end
	end

	// gather the examined lines of this step into the key vector
	always_comb
	begin
		frame_next = frame_reg;
		for (int i = 0; i < key_scan_pkg::LINE_COUNT; i++)
		begin
			if (key_scan_pkg::READ_MASK[step_reg][i])
				frame_next[key_scan_pkg::KEY_BASE[step_reg] + i
					- (key_scan_pkg::LINE_COUNT - $countones(key_scan_pkg::READ_MASK[step_reg]))]
					= ~line_level[i];
		end
	end

	// frame accumulation and report at the end of step six
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			frame_reg <= '0;
			report_reg <= '0;
		end
		else
		begin
			report_reg.frame_done <= 1'b0;
			if (phase_reg == ST_SAMPLE)
			begin
				frame_reg <= frame_next;
				if (step_reg == key_scan_pkg::STEP_LAST)
				begin
					report_reg.closed <= frame_next;
					report_reg.frame_done <= 1'b1;
				end
			end
		end
	end

	assign key_line_out = drive_reg.out_val;
	assign key_line_oe_out = drive_reg.out_en;
	assign key_closed_out = report_reg.closed;
	assign scan_done_out = report_reg.frame_done;
	assign scan_step_out = step_reg;
endmodule : front_panel_key_matrix_scanner
`default_nettype wire

// ---- design/key_scan_pkg.sv ----
// package: constants and carrier types for the front panel key matrix scanner
`default_nettype none
package key_scan_pkg;
	localparam int LINE_COUNT = 6;
	localparam int STEP_COUNT = 6;
	localparam int KEY_COUNT = 19;
	// settle time of one scan step in microseconds and its cycle count at 10 MHz
	localparam int CLK_HZ = 10000000;
	localparam int STEP_TIME_US = 100;
	localparam int STEP_CYCLES = (STEP_TIME_US * (CLK_HZ / 1000000));
	localparam logic [2:0] STEP_FIRST = 3'h0;
	localparam logic [2:0] STEP_LAST = 3'h5;
	localparam logic [5:0] LINES_IDLE = 6'h3f;
	// per step: line driven low (bit set) and lines examined for closures
	localparam logic [5:0] DRIVE_MASK [STEP_COUNT] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10};
	localparam logic [5:0] READ_MASK [STEP_COUNT] = '{6'h3f, 6'h3e, 6'h3c, 6'h38, 6'h00, 6'h20};
	// position of each step's first key in the flat key vector
	localparam int KEY_BASE [STEP_COUNT] = '{0, 6, 11, 15, 18, 18};

	typedef struct packed {
		logic [5:0] out_val;
		logic [5:0] out_en;
	} key_line_drive_type;

	typedef struct packed {
		logic [KEY_COUNT-1:0] closed;
		logic frame_done;
	} key_report_type;
endpackage : key_scan_pkg
`default_nettype wire

// ---- design/key_line_sync.sv ----
// two-flop synchroniser for the key line pins
`default_nettype none
module key_line_sync #(
	parameter int WIDTH = 6
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// pins in, synchronised levels out
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			meta_reg <= '1;
			level_out <= '1;
		end
		else
		begin
			meta_reg <= pin_in;
			level_out <= meta_reg;
		end
	end
endmodule : key_line_sync
`default_nettype wire

// ---- verification/key_matrix_model.sv ----
// partner: pulled-up key lines and the switch matrix
`default_nettype none
module key_matrix_model (
	input wire logic [5:0] drive_in,
	input wire logic [5:0] enable_in,
	input wire logic [18:0] keys_in,
	output logic [5:0] level_out
);
	// pull-ups and drives, then closed keys join lines
	always_comb
	begin
		logic [5:0] lo;
		int b;
		lo = (~enable_in | drive_in) & ~keys_in[5:0];
		level_out = lo;
		b = 6;
		for (int s = 0; s < 3; s++)
			for (int r = s + 1; r < 6; r++)
			begin
				if (keys_in[b])
				begin
					level_out[s] = level_out[s] & lo[r];
					level_out[r] = level_out[r] & lo[s];
				end
				b++;
			end
		if (keys_in[18])
			level_out[5:4] = {2{&lo[5:4]}};
	end
endmodule : key_matrix_model
`default_nettype wire

// ---- verification/key_scan_checker.sv ----
// checker: scan order and strobes of the key scanner
`default_nettype none
module key_scan_checker (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [5:0] key_line_out,
	input wire logic [5:0] key_line_oe_out,
	input wire logic [key_scan_pkg::KEY_COUNT-1:0] key_closed_out,
	input wire logic scan_done_out,
	input wire logic [2:0] scan_step_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	a_drive_low_only: assert property (key_line_out == 6'h00) else $error("drive high");
	a_one_strobe: assert property ($onehot0(key_line_oe_out)) else $error("two strobes");
	a_strobe_step: assert property (key_line_oe_out ==
		key_scan_pkg::DRIVE_MASK[$past(scan_step_out)]) else $error("strobe");
	a_step_order: assert property ($changed(scan_step_out) |-> scan_step_out ==
		(($past(scan_step_out) == 3'h5) ? 3'h0 : $past(scan_step_out) + 3'h1)) else $error("order");
	a_step_range: assert property (scan_step_out <= 3'h5) else $error("step range");
	a_first_released: assert property ($changed(scan_step_out) && scan_step_out == 3'h0
		|=> key_line_oe_out == 6'h00) else $error("step one");
	a_report_hold: assert property (!scan_done_out |-> $stable(key_closed_out)) else $error("keys");
	a_done_spacing: assert property (scan_done_out |=> !scan_done_out[*8]) else $error("done");
	c_frame: cover property (scan_done_out);
	c_key: cover property (scan_done_out && key_closed_out != 0);
	c_last: cover property (scan_step_out == 3'h5);
endmodule : key_scan_checker
bind front_panel_key_matrix_scanner key_scan_checker chk_u (.clk_sys_in(clk_sys_in),
	.rst_in(rst_in), .key_line_out(key_line_out), .key_line_oe_out(key_line_oe_out),
	.key_closed_out(key_closed_out), .scan_done_out(scan_done_out),
	.scan_step_out(scan_step_out));
`default_nettype wire

// ---- verification/front_panel_key_matrix_scanner_bench.sv ----
// bench: presses keys and checks the frame report
`default_nettype none
module front_panel_key_matrix_scanner_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic [18:0] keys = 19'h00000;
	wire logic [5:0] lvl;
	wire logic [5:0] drv;
	wire logic [5:0] oe;
	wire logic [18:0] closed;
	wire logic done;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	// clock, design and switch matrix
	always #50 clk_sys_in = ~clk_sys_in;
	front_panel_key_matrix_scanner #(.STEP_CYCLES(4)) dut_u (.clk_sys_in(clk_sys_in),
		.rst_in(rst_in), .key_line_in(lvl), .key_line_out(drv), .key_line_oe_out(oe),
		.key_closed_out(closed), .scan_done_out(done), .scan_step_out());
	key_matrix_model model_u (.drive_in(drv), .enable_in(oe), .keys_in(keys), .level_out(lvl));
	// hang guard
	always @(posedge clk_sys_in)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			fails++;
			complete_run();
		end
	end
	// a key to ground on line 2..6 is also read low in every strobe step that examines that line
	function automatic logic [18:0] with_ghosts(input logic [18:0] k);
		logic [18:0] e;
		e = k;
		e[6] = e[6] | k[1];
		e[7] = e[7] | k[2];
		e[11] = e[11] | k[2];
		e[8] = e[8] | k[3];
		e[12] = e[12] | k[3];
		e[15] = e[15] | k[3];
		e[9] = e[9] | k[4];
		e[13] = e[13] | k[4];
		e[16] = e[16] | k[4];
		e[10] = e[10] | k[5];
		e[14] = e[14] | k[5];
		e[17] = e[17] | k[5];
		e[18] = e[18] | k[5];
		return e;
	endfunction : with_ghosts
	task automatic scan_with(input logic [18:0] k);
		int n;
		logic [18:0] want;
		want = with_ghosts(k);
		keys = k;
		repeat (2)
		begin
			n = 0;
			do
			begin
				@(posedge clk_sys_in);
				#1;
				n++;
			end
			while (done !== 1'b1 && n < 100);
			if (n >= 100)
			begin
				fails++;
				$display("[FAIL] scan_done_out expected 1 seen %b", done);
			end
		end
		total_checks++;
		if (closed !== want)
		begin
			fails++;
			$display("[FAIL] key_closed_out expected %h seen %h", want, closed);
		end
	endtask : scan_with
	task automatic complete_run();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	// reset, idle, each key alone, then two keys at once
	initial
	begin
		repeat (20) @(posedge clk_sys_in);
		#1 rst_in = 1'b0;
		scan_with(19'h00000);
		for (int i = 0; i < 19; i++)
			scan_with(19'h00001 << i);
		scan_with(19'h40001);
		complete_run();
	end
endmodule : front_panel_key_matrix_scanner_bench
`default_nettype wire
